// file: flash_array_model.sv
// Behavioural flash array facing the program/erase controller.
// Assumes one start pulse per operation; answers once after a bench-set delay.
`timescale 1ns/1ps
`default_nettype none

module flash_array_model (
  // System.
  input wire logic system_clock,
  input wire logic sysRst,
  // Controller side.
  input wire flash_ctrl_pkg::array_req_t arrayReq,
  output flash_ctrl_pkg::array_resp_t arrayResp,
  // Bench control.
  input wire logic [7:0] latency,
  input wire logic protectMode,
  input wire logic dirtyMode
);
  logic [7:0] count_q;
  logic junk_q;

  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      count_q <= 8'h00;
    end else if (arrayReq.start) begin
      count_q <= latency;
    end else if (count_q != 8'h00) begin
      count_q <= count_q - 8'h01;
    end
  end

  always_ff @(posedge system_clock) begin
    junk_q <= sysRst ? 1'b0 : ~junk_q;
  end

  // Outside the finish pulse the fields carry a toggling pattern, so a controller that
  // samples them late cannot pass by luck.
  always_comb begin
    if (count_q == 8'h01) begin
      arrayResp = {1'b1, protectMode, 1'b1, dirtyMode ? 16'h0F0F : 16'hFFFF};
    end else begin
      arrayResp = {1'b0, junk_q, ~junk_q, {16{junk_q}}};
    end
  end
endmodule
`default_nettype wire

// file: flash_ctrl_pkg.sv
// Package for the flash program/erase control block: register map, field positions,
// reset values, key words and the structs that carry array requests and answers.
// Assumes a 32-bit word-wide register port and one system clock.
package flash_ctrl_pkg;

  // Register byte offsets.
  localparam logic [7:0] ACCESS_CONTROL_OFS = 8'h00;
  localparam logic [7:0] ARRAY_UNLOCK_KEY_OFS = 8'h04;
  localparam logic [7:0] OPTION_UNLOCK_KEY_OFS = 8'h08;
  localparam logic [7:0] OPERATION_STATUS_OFS = 8'h0C;
  localparam logic [7:0] OPERATION_CONTROL_OFS = 8'h10;

  // Access control fields.
  localparam int ACR_LATENCY_LSB = 0;
  localparam int ACR_PREFETCH_ENABLE = 4;
  localparam int ACR_PREFETCH_STATE = 5;
  localparam logic [2:0] LATENCY_ZERO_WAIT = 3'h0;
  localparam logic [2:0] LATENCY_ONE_WAIT = 3'h1;
  localparam logic [31:0] ACCESS_CONTROL_RESET = 32'h0000_0000;

  // Status fields.
  localparam int SR_IN_FLIGHT = 0;
  localparam int SR_NOT_BLANK = 2;
  localparam int SR_PROTECT = 4;
  localparam int SR_DONE = 5;
  localparam logic [31:0] OPERATION_STATUS_RESET = 32'h0000_0000;

  // Control fields.
  localparam int CR_WORD_PROGRAM = 0;
  localparam int CR_PAGE_ERASE = 1;
  localparam int CR_MASS_ERASE = 2;
  localparam int CR_OPTION_PROGRAM = 4;
  localparam int CR_OPTION_ERASE = 5;
  localparam int CR_ERASE_TRIGGER = 6;
  localparam int CR_LOCK = 7;
  localparam int CR_OPTION_GRANTED = 9;
  localparam int CR_FAULT_IRQ_EN = 10;
  localparam int CR_DONE_IRQ_EN = 12;
  localparam int CR_OPTION_RELOAD = 13;
  localparam logic [31:0] OPERATION_CONTROL_RESET = 32'h0000_0080;

  // Unlock key words, first then second. Values are arbitrary.
  localparam logic [31:0] UNLOCK_WORD_FIRST = 32'h1357_9BDF;
  localparam logic [31:0] UNLOCK_WORD_SECOND = 32'h2468_ACE0;

  // Word that a blank location reads before programming.
  localparam logic [15:0] BLANK_WORD = 16'hFFFF;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_WORD_PROGRAM = 3'h1,
    OP_PAGE_ERASE = 3'h2,
    OP_MASS_ERASE = 3'h3,
    OP_OPTION_PROGRAM = 3'h4,
    OP_OPTION_ERASE = 3'h5
  } op_kind_t;

  // Request to the array: one-cycle start with the operation kind.
  typedef struct packed {
    logic start;
    op_kind_t kind;
  } array_req_t;

  // Answer from the array: one-cycle finish with the reasons for failure.
  typedef struct packed {
    logic finish;
    logic protectHit;
    logic oldWordValid;
    logic [15:0] oldWord;
  } array_resp_t;

endpackage

// file: flash_program_erase_ctrl.sv
// Control and status logic of the flash program/erase interface.
// Assumes a word-wide register port with one-cycle strobes and an array that answers
// each started operation with exactly one finish pulse.
//
// Contract
// - Done flag with done enable raises interrupt.
// - Either fault flag with fault enable raises interrupt.
// - Prefetch enable bit switches prefetch off/on.
// - Prefetch state sets on first enabled fetch.
// - Wait-state field: 000 none, 001 one.
// - Both key registers write-only, read zero.
// - Done flag sets on success, write-1 clears.
// - Protect flag sets on protected program, write-1 clears.
// - Not-blank flag sets on non-blank target, write-1 clears.
// - Busy sets at start, clears at finish/error.
// - Option reload request forces reload and reset.
// - Option grant set by key sequence, software clears.
// - Lock resets to one, software sets only.
// - Failed unlock keeps lock until reset.
// - Erase trigger launches erase, clears with busy.
// - One select bit per operation type.
// - Protected target sets protect flag, array untouched.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none

module flash_program_erase_ctrl (
  // System.
  input wire logic system_clock,
  input wire logic sysRst,
  // Register port.
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdData,
  // Core side: a data write into the flash space and instruction fetches.
  input wire logic flashWrite,
  input wire logic fetchRequest,
  // Array side.
  output flash_ctrl_pkg::array_req_t arrayReq,
  input wire flash_ctrl_pkg::array_resp_t arrayResp,
  // Settings and events toward the system.
  output logic [2:0] waitStates,
  output logic prefetchOn,
  output logic flashIrq,
  output logic optionReloadReset
);

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    LAUNCH = 2'b01,
    RUN = 2'b11
  } seq_state_t;

  typedef enum logic [1:0] {
    KEY_FIRST = 2'b00,
    KEY_SECOND = 2'b01,
    KEY_BARRED = 2'b11
  } key_state_t;

  seq_state_t seqState_q;
  key_state_t arrayKey_q;
  key_state_t optionKey_q;
  logic [2:0] latency_q;
  logic prefetchEnable_q;
  logic prefetchState_q;
  logic opDone_q;
  logic protectViolation_q;
  logic notBlankFault_q;
  logic inFlight_q;
  logic [5:0] selects_q;
  logic eraseTrigger_q;
  logic lock_q;
  logic optionGranted_q;
  logic faultIrqEn_q;
  logic doneIrqEn_q;
  logic optionReload_q;
  flash_ctrl_pkg::op_kind_t pendingKind_q;
  flash_ctrl_pkg::array_req_t arrayReq_q;
  logic [31:0] rdData_q;
  logic irq_q;

  logic wrAcr;
  logic wrSr;
  logic wrCr;
  logic wrArrayKey;
  logic wrOptionKey;
  logic eraseLaunch;
  logic programLaunch;
  logic finishOk;
  logic finishProtect;
  logic finishNotBlank;
  flash_ctrl_pkg::op_kind_t eraseKind;
  flash_ctrl_pkg::op_kind_t programKind;

  // Sub-word accesses cannot occur here: the port carries whole words only.
  assign wrAcr = regWrite && regAddr == flash_ctrl_pkg::ACCESS_CONTROL_OFS;
  assign wrArrayKey = regWrite && regAddr == flash_ctrl_pkg::ARRAY_UNLOCK_KEY_OFS;
  assign wrOptionKey = regWrite && regAddr == flash_ctrl_pkg::OPTION_UNLOCK_KEY_OFS;
  assign wrSr = regWrite && regAddr == flash_ctrl_pkg::OPERATION_STATUS_OFS;
  assign wrCr = regWrite && regAddr == flash_ctrl_pkg::OPERATION_CONTROL_OFS;

  // Mass erase wins over page erase, which wins over option erase.
  always_comb begin
    if (selects_q[flash_ctrl_pkg::CR_MASS_ERASE]) begin
      eraseKind = flash_ctrl_pkg::OP_MASS_ERASE;
    end else if (selects_q[flash_ctrl_pkg::CR_PAGE_ERASE]) begin
      eraseKind = flash_ctrl_pkg::OP_PAGE_ERASE;
    end else if (selects_q[flash_ctrl_pkg::CR_OPTION_ERASE] && optionGranted_q) begin
      eraseKind = flash_ctrl_pkg::OP_OPTION_ERASE;
    end else begin
      eraseKind = flash_ctrl_pkg::OP_NONE;
    end
  end

  always_comb begin
    if (selects_q[flash_ctrl_pkg::CR_WORD_PROGRAM]) begin
      programKind = flash_ctrl_pkg::OP_WORD_PROGRAM;
    end else if (selects_q[flash_ctrl_pkg::CR_OPTION_PROGRAM] && optionGranted_q) begin
      programKind = flash_ctrl_pkg::OP_OPTION_PROGRAM;
    end else begin
      programKind = flash_ctrl_pkg::OP_NONE;
    end
  end

  // A trigger write is taken only unlocked, idle, and with an erase selected.
  assign eraseLaunch = wrCr && regWrData[flash_ctrl_pkg::CR_ERASE_TRIGGER] && !lock_q
                       && seqState_q == IDLE && eraseKind != flash_ctrl_pkg::OP_NONE;
  // A program starts on a write into the flash space while a program type is selected.
  // An erase trigger still set blocks it; software cannot clear it, only the finish of the erase does.
  assign programLaunch = flashWrite && !lock_q && seqState_q == IDLE && !eraseTrigger_q
                         && programKind != flash_ctrl_pkg::OP_NONE;

  // Error cases take priority over success; the array leaves the cells alone on them.
  assign finishProtect = seqState_q == RUN && arrayResp.finish && arrayResp.protectHit;
  assign finishNotBlank = seqState_q == RUN && arrayResp.finish && !arrayResp.protectHit
                          && arrayResp.oldWordValid && arrayResp.oldWord != flash_ctrl_pkg::BLANK_WORD;
  assign finishOk = seqState_q == RUN && arrayResp.finish && !finishProtect && !finishNotBlank;

  // Operation sequencer.
  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      seqState_q <= IDLE;
      pendingKind_q <= flash_ctrl_pkg::OP_NONE;
    end else begin
      unique case (seqState_q)
        IDLE: begin
          if (eraseLaunch) begin
            seqState_q <= LAUNCH;
            pendingKind_q <= eraseKind;
          end else if (programLaunch) begin
            seqState_q <= LAUNCH;
            pendingKind_q <= programKind;
          end
        end
        LAUNCH: begin
          seqState_q <= RUN;
        end
        RUN: begin
          if (arrayResp.finish) begin
            seqState_q <= IDLE;
          end
        end
        default: begin
          seqState_q <= IDLE;
        end
      endcase
    end
  end

  // Start pulse to the array, issued from the launch state.
  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      arrayReq_q <= '0;
    end else begin
      arrayReq_q.start <= seqState_q == LAUNCH;
      arrayReq_q.kind <= (seqState_q == LAUNCH) ? pendingKind_q : flash_ctrl_pkg::OP_NONE;
    end
  end

  // Busy rises with the launch and falls with the finish, error or not.
  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      inFlight_q <= 1'b0;
    end else if (seqState_q == LAUNCH) begin
      inFlight_q <= 1'b1;
    end else if (seqState_q == RUN && arrayResp.finish) begin
      inFlight_q <= 1'b0;
    end
  end

  // Sticky status flags: a set in the same cycle as a write-1 clear wins.
  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      opDone_q <= 1'b0;
      protectViolation_q <= 1'b0;
      notBlankFault_q <= 1'b0;
    end else begin
      opDone_q <= finishOk || (opDone_q && !(wrSr && regWrData[flash_ctrl_pkg::SR_DONE]));
      protectViolation_q <= finishProtect
                            || (protectViolation_q && !(wrSr && regWrData[flash_ctrl_pkg::SR_PROTECT]));
      notBlankFault_q <= finishNotBlank
                         || (notBlankFault_q && !(wrSr && regWrData[flash_ctrl_pkg::SR_NOT_BLANK]));
    end
  end

  // Array key sequence; any wrong word bars further attempts until reset.
  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      arrayKey_q <= KEY_FIRST;
    end else if (wrArrayKey) begin
      unique case (arrayKey_q)
        KEY_FIRST: begin
          arrayKey_q <= (regWrData == flash_ctrl_pkg::UNLOCK_WORD_FIRST) ? KEY_SECOND : KEY_BARRED;
        end
        KEY_SECOND: begin
          arrayKey_q <= (regWrData == flash_ctrl_pkg::UNLOCK_WORD_SECOND) ? KEY_FIRST : KEY_BARRED;
        end
        KEY_BARRED: begin
          arrayKey_q <= KEY_BARRED;
        end
        default: begin
          arrayKey_q <= KEY_BARRED;
        end
      endcase
    end
  end

  // Option key sequence, same words; it is honoured only once the array is unlocked.
  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      optionKey_q <= KEY_FIRST;
    end else if (wrOptionKey) begin
      unique case (optionKey_q)
        KEY_FIRST: begin
          optionKey_q <= (regWrData == flash_ctrl_pkg::UNLOCK_WORD_FIRST) ? KEY_SECOND : KEY_BARRED;
        end
        KEY_SECOND: begin
          optionKey_q <= (regWrData == flash_ctrl_pkg::UNLOCK_WORD_SECOND) ? KEY_FIRST : KEY_BARRED;
        end
        KEY_BARRED: begin
          optionKey_q <= KEY_BARRED;
        end
        default: begin
          optionKey_q <= KEY_BARRED;
        end
      endcase
    end
  end

  // Lock: software can only set it; the second good key clears it.
  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      lock_q <= flash_ctrl_pkg::OPERATION_CONTROL_RESET[flash_ctrl_pkg::CR_LOCK];
    end else if (wrCr && regWrData[flash_ctrl_pkg::CR_LOCK]) begin
      lock_q <= 1'b1;
    end else if (wrArrayKey && arrayKey_q == KEY_SECOND
                 && regWrData == flash_ctrl_pkg::UNLOCK_WORD_SECOND) begin
      lock_q <= 1'b0;
    end
  end

  // Option grant: hardware sets on the good sequence, software may clear.
  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      optionGranted_q <= 1'b0;
    end else if (wrOptionKey && optionKey_q == KEY_SECOND && !lock_q
                 && regWrData == flash_ctrl_pkg::UNLOCK_WORD_SECOND) begin
      optionGranted_q <= 1'b1;
    end else if (wrCr && !regWrData[flash_ctrl_pkg::CR_OPTION_GRANTED]) begin
      optionGranted_q <= 1'b0;
    end
  end

  // Select bits and trigger; frozen while locked or busy so a running job keeps its type.
  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      selects_q <= '0;
    end else if (wrCr && !lock_q && seqState_q == IDLE) begin
      selects_q <= regWrData[5:0] & 6'h37;
    end
  end

  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      eraseTrigger_q <= 1'b0;
    end else if (eraseLaunch) begin
      eraseTrigger_q <= 1'b1;
    end else if (inFlight_q && seqState_q == RUN && arrayResp.finish) begin
      eraseTrigger_q <= 1'b0;
    end
  end

  // Interrupt enables and the option reload request.
  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      faultIrqEn_q <= 1'b0;
      doneIrqEn_q <= 1'b0;
    end else if (wrCr) begin
      faultIrqEn_q <= regWrData[flash_ctrl_pkg::CR_FAULT_IRQ_EN];
      doneIrqEn_q <= regWrData[flash_ctrl_pkg::CR_DONE_IRQ_EN];
    end
  end

  // The request stays up until the system reset it causes clears it.
  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      optionReload_q <= 1'b0;
    end else if (wrCr && regWrData[flash_ctrl_pkg::CR_OPTION_RELOAD]) begin
      optionReload_q <= 1'b1;
    end
  end

  // Access control: latency and prefetch.
  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      latency_q <= flash_ctrl_pkg::ACCESS_CONTROL_RESET[2:0];
      prefetchEnable_q <= 1'b0;
    end else if (wrAcr) begin
      latency_q <= regWrData[flash_ctrl_pkg::ACR_LATENCY_LSB +: 3];
      prefetchEnable_q <= regWrData[flash_ctrl_pkg::ACR_PREFETCH_ENABLE];
    end
  end

  // The buffer only counts as active after a real fetch with prefetch on.
  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      prefetchState_q <= 1'b0;
    end else if (!prefetchEnable_q) begin
      prefetchState_q <= 1'b0;
    end else if (fetchRequest) begin
      prefetchState_q <= 1'b1;
    end
  end

  // Interrupt request.
  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (opDone_q && doneIrqEn_q) || ((protectViolation_q || notBlankFault_q) && faultIrqEn_q);
    end
  end

  // Read data, one cycle after the strobe; keys and unmapped addresses read zero.
  always_ff @(posedge system_clock) begin
    if (sysRst) begin
      rdData_q <= '0;
    end else if (regRead) begin
      rdData_q <= '0;
      unique case (regAddr)
        flash_ctrl_pkg::ACCESS_CONTROL_OFS: begin
          rdData_q <= {26'h0, prefetchState_q, prefetchEnable_q, 1'b0, latency_q};
        end
        flash_ctrl_pkg::OPERATION_STATUS_OFS: begin
          rdData_q <= {26'h0, opDone_q, protectViolation_q, 1'b0, notBlankFault_q, 1'b0, inFlight_q};
        end
        flash_ctrl_pkg::OPERATION_CONTROL_OFS: begin
          rdData_q <= {18'h0, optionReload_q, doneIrqEn_q, 1'b0, faultIrqEn_q, optionGranted_q,
                       1'b0, lock_q, eraseTrigger_q, selects_q};
        end
        default: begin
          rdData_q <= '0;
        end
      endcase
    end
  end

  assign regRdData = rdData_q;
  assign arrayReq = arrayReq_q;
  assign waitStates = latency_q;
  assign prefetchOn = prefetchEnable_q;
  assign flashIrq = irq_q;
  assign optionReloadReset = optionReload_q;

  // Checks.
  sequence keyPair_s;
    wrArrayKey && regWrData == flash_ctrl_pkg::UNLOCK_WORD_FIRST && arrayKey_q == KEY_FIRST
    ##[1:5] wrArrayKey && regWrData == flash_ctrl_pkg::UNLOCK_WORD_SECOND && arrayKey_q == KEY_SECOND;
  endsequence

  sequence launchRun_s;
    seqState_q == LAUNCH ##1 seqState_q == RUN;
  endsequence

  unlock_clears_lock_a: assert property (@(posedge system_clock) disable iff (sysRst)
    keyPair_s |=> !lock_q) else $error("Lock not cleared after good key pair.");
  barred_stays_locked_a: assert property (@(posedge system_clock) disable iff (sysRst)
    arrayKey_q == KEY_BARRED && lock_q |=> lock_q) else $error("Lock cleared after failed unlock.");
  busy_follows_launch_a: assert property (@(posedge system_clock) disable iff (sysRst)
    launchRun_s |-> inFlight_q && arrayReq.start) else $error("Busy or start missing after launch.");
  busy_drops_finish_a: assert property (@(posedge system_clock) disable iff (sysRst)
    seqState_q == RUN && arrayResp.finish |=> !inFlight_q && !eraseTrigger_q)
    else $error("Busy or trigger held after finish.");
  done_sets_ok_a: assert property (@(posedge system_clock) disable iff (sysRst)
    finishOk |=> opDone_q ##1 (opDone_q || $past(wrSr))) else $error("Done flag not set.");
  fault_flags_a: assert property (@(posedge system_clock) disable iff (sysRst)
    finishProtect |=> protectViolation_q && !opDone_q || $past(opDone_q))
    else $error("Protect flag not set on violation.");
  irq_done_a: assert property (@(posedge system_clock) disable iff (sysRst)
    opDone_q && doneIrqEn_q |=> flashIrq) else $error("Done interrupt missing.");
  irq_fault_a: assert property (@(posedge system_clock) disable iff (sysRst)
    !opDone_q && !(protectViolation_q || notBlankFault_q) |=> !flashIrq)
    else $error("Interrupt without cause.");
  locked_no_start_a: assert property (@(posedge system_clock) disable iff (sysRst)
    lock_q && seqState_q == IDLE |=> seqState_q == IDLE) else $error("Operation started while locked.");
  key_reads_zero_a: assert property (@(posedge system_clock) disable iff (sysRst)
    regRead && (regAddr == flash_ctrl_pkg::ARRAY_UNLOCK_KEY_OFS
                || regAddr == flash_ctrl_pkg::OPTION_UNLOCK_KEY_OFS) |=> regRdData == 32'h0)
    else $error("Key register read nonzero.");

endmodule

`default_nettype wire

// file: flash_program_erase_ctrl_tb.sv
// Self-checking bench for the flash program/erase controller.
// Assumes the array model beside it and a 50 MHz system clock.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin nCompared++; if ((got) !== (exp)) begin fails++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module flash_program_erase_ctrl_tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [2:0] ws; logic pf;} reg_row_t;
  typedef struct {logic [31:0] cr; logic trig; logic prot; logic dirty;
    flash_ctrl_pkg::op_kind_t kind; logic [31:0] sr; logic irq;} op_row_t;

  logic system_clock = 1'b0;
  logic sysRst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic flashWrite = 1'b0;
  logic fetchRequest = 1'b0;
  logic protectMode = 1'b0;
  logic dirtyMode = 1'b0;
  logic [31:0] regRdData;
  flash_ctrl_pkg::array_req_t arrayReq;
  flash_ctrl_pkg::array_resp_t arrayResp;
  logic [2:0] waitStates;
  logic prefetchOn;
  logic flashIrq;
  logic optionReloadReset;
  logic [31:0] d;
  int fails = 0;
  int nCompared = 0;

  // All rows run while the array is still locked.
  reg_row_t regRows [8] = '{
    '{8'h00, 32'h11, 32'h11, 3'h1, 1'b1}, '{8'h00, 32'h10, 32'h10, 3'h0, 1'b1},
    '{8'h00, 32'h01, 32'h01, 3'h1, 1'b0}, '{8'h00, 32'h00, 32'h00, 3'h0, 1'b0},
    '{8'h0C, 32'hFFFF_FFFF, 32'h00, 3'h0, 1'b0}, '{8'h10, 32'h00, 32'h80, 3'h0, 1'b0},
    '{8'h10, 32'h47, 32'h80, 3'h0, 1'b0}, '{8'h14, 32'h1234_5678, 32'h00, 3'h0, 1'b0}};

  op_row_t opRows [9] = '{
    '{32'h1601, 1'b0, 1'b0, 1'b0, flash_ctrl_pkg::OP_WORD_PROGRAM, 32'h20, 1'b1},
    '{32'h1601, 1'b0, 1'b1, 1'b0, flash_ctrl_pkg::OP_WORD_PROGRAM, 32'h10, 1'b1},
    '{32'h1601, 1'b0, 1'b0, 1'b1, flash_ctrl_pkg::OP_WORD_PROGRAM, 32'h04, 1'b1},
    '{32'h0201, 1'b0, 1'b0, 1'b0, flash_ctrl_pkg::OP_WORD_PROGRAM, 32'h20, 1'b0},
    '{32'h1642, 1'b1, 1'b0, 1'b0, flash_ctrl_pkg::OP_PAGE_ERASE, 32'h20, 1'b1},
    '{32'h1642, 1'b1, 1'b1, 1'b0, flash_ctrl_pkg::OP_PAGE_ERASE, 32'h10, 1'b1},
    '{32'h1644, 1'b1, 1'b0, 1'b0, flash_ctrl_pkg::OP_MASS_ERASE, 32'h20, 1'b1},
    '{32'h1660, 1'b1, 1'b0, 1'b0, flash_ctrl_pkg::OP_OPTION_ERASE, 32'h20, 1'b1},
    '{32'h1610, 1'b0, 1'b0, 1'b0, flash_ctrl_pkg::OP_OPTION_PROGRAM, 32'h20, 1'b1}};

  always #10 system_clock = ~system_clock;

  flash_program_erase_ctrl dut_u (
    .system_clock(system_clock), .sysRst(sysRst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .flashWrite(flashWrite),
    .fetchRequest(fetchRequest), .arrayReq(arrayReq), .arrayResp(arrayResp),
    .waitStates(waitStates), .prefetchOn(prefetchOn), .flashIrq(flashIrq),
    .optionReloadReset(optionReloadReset));

  flash_array_model model_u (
    .system_clock(system_clock), .sysRst(sysRst), .arrayReq(arrayReq), .arrayResp(arrayResp),
    .latency(8'h08), .protectMode(protectMode), .dirtyMode(dirtyMode));

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Every access is a whole 32-bit word.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge system_clock);
    regAddr <= a;
    regWrData <= v;
    regWrite <= 1'b1;
    @(posedge system_clock);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge system_clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge system_clock);
    regRead <= 1'b0;
    @(negedge system_clock);
    v = regRdData;
  endtask

  task automatic unlock(input logic [7:0] a);
    wr(a, flash_ctrl_pkg::UNLOCK_WORD_FIRST);
    wr(a, flash_ctrl_pkg::UNLOCK_WORD_SECOND);
  endtask

  task automatic do_reset;
    @(posedge system_clock);
    sysRst <= 1'b1;
    repeat (2) @(posedge system_clock);
    sysRst <= 1'b0;
  endtask

  task automatic await(input logic fin);
    for (int i = 0; i < 40; i++) begin
      @(negedge system_clock);
      if ((fin ? arrayResp.finish : arrayReq.start) === 1'b1) return;
    end
    `CHK(1'b0, 1'b1)
    tally_and_finish;
  endtask

  initial begin
    #1000000;
    `CHK(1'b0, 1'b1)
    tally_and_finish;
  end

  initial begin
    repeat (2) @(posedge system_clock);
    sysRst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(8'(4 * i), d);
      `CHK(d, (i == 4) ? 32'h80 : 32'h0)
    end
    foreach (regRows[i]) begin
      wr(regRows[i].a, regRows[i].d);
      rd(regRows[i].a, d);
      `CHK(d, regRows[i].e)
      `CHK({waitStates, prefetchOn}, {regRows[i].ws, regRows[i].pf})
    end
    $display("register table done");
    wr(8'h00, 32'h10);
    @(posedge system_clock);
    fetchRequest <= 1'b1;
    @(posedge system_clock);
    fetchRequest <= 1'b0;
    rd(8'h00, d);
    `CHK(d, 32'h30)
    $display("prefetch state done");
    wr(8'h04, flash_ctrl_pkg::UNLOCK_WORD_FIRST);
    wr(8'h04, 32'h0);
    unlock(8'h04);
    rd(8'h10, d);
    `CHK(d, 32'h80)
    do_reset;
    unlock(8'h04);
    rd(8'h10, d);
    `CHK(d, 32'h0)
    unlock(8'h08);
    rd(8'h10, d);
    `CHK(d, 32'h200)
    $display("unlock done");
    foreach (opRows[i]) begin
      protectMode <= opRows[i].prot;
      dirtyMode <= opRows[i].dirty;
      wr(8'h10, opRows[i].cr & ~32'h40);
      if (opRows[i].trig) begin
        wr(8'h10, opRows[i].cr);
      end else begin
        @(posedge system_clock);
        flashWrite <= 1'b1;
        @(posedge system_clock);
        flashWrite <= 1'b0;
      end
      await(1'b0);
      `CHK(arrayReq.kind, opRows[i].kind)
      rd(8'h0C, d);
      `CHK(d[0], 1'b1)
      await(1'b1);
      rd(8'h0C, d);
      `CHK(d, opRows[i].sr)
      `CHK(flashIrq, opRows[i].irq)
      rd(8'h10, d);
      `CHK(d[6], 1'b0)
      wr(8'h0C, 32'h34);
      rd(8'h0C, d);
      `CHK(d, 32'h0)
      `CHK(flashIrq, 1'b0)
      $display("operation row %0d done", i);
    end
    wr(8'h10, 32'h0);
    rd(8'h10, d);
    `CHK(d[9], 1'b0)
    wr(8'h10, 32'h2000);
    repeat (2) @(negedge system_clock);
    `CHK(optionReloadReset, 1'b1)
    do_reset;
    @(negedge system_clock);
    `CHK(optionReloadReset, 1'b0)
    wr(8'h10, 32'h1);
    @(posedge system_clock);
    flashWrite <= 1'b1;
    @(posedge system_clock);
    flashWrite <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      @(negedge system_clock);
      `CHK(arrayReq.start, 1'b0)
    end
    $display("locked refusal done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
